// file: logic/mlt_fifo_ram.sv
`timescale 1ns/10ps
`include "mlt_regs.svh"
module mlt_fifo_ram (
  input wire logic clk,
  mlt_ram_if.store bus
);
  logic [`MLT_RAM_DW-1:0] mem [`MLT_FIFO_DEPTH];

  // Read data is registered so the array maps onto block memory.
  always_ff @(posedge clk) begin
    if (bus.ce) begin
      if (bus.wrEn) begin
        mem[bus.wrAddr] <= bus.wrData;
      end
      bus.rdData <= mem[bus.rdAddr];
    end
  end
endmodule

// file: logic/mlt_loopback_harness.sv
`timescale 1ns/10ps
`include "mlt_regs.svh"
// What this block does
// - Loop received frames through FIFO to transmit.
// - Optionally swap destination and source addresses.
// - Driver repeats stored frame with gap.
// - Select pin picks driver or external port.
// - Monitor flags returning frame mismatches.
// - Sixteen-bit counters count statistics events.
// - Control and status registers on slave port.
// - Registers are bytes; counters split low/high.
// - Low byte read clears whole counter.
module mlt_loopback_harness (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxEof,
  output logic [7:0] txData,
  output logic txValid,
  output logic txEof,
  input wire logic txReady,
  input wire logic [`MLT_RX_EV_NUM-1:0] rxStatEv,
  input wire logic [`MLT_TX_EV_NUM-1:0] txStatEv,
  input wire logic [7:0] macRxStatus,
  input wire logic [7:0] macTxStatus,
  output logic [7:0] macControl,
  input wire logic [7:0] usAddr,
  input wire logic usWrite,
  input wire logic usRead,
  input wire logic [7:0] usWdata,
  output logic [7:0] usRdata,
  input wire logic extSelect,
  input wire logic [7:0] extTxData,
  input wire logic extTxEn,
  output logic [7:0] linkTxData,
  output logic linkTxEn,
  input wire logic [7:0] linkRxData,
  input wire logic linkRxDv,
  output logic monFail
);
  // ==========================================================
  // Shared decoding
  function automatic logic [31:0] crcByte(input logic [31:0] c,
                                         input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ `MLT_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Stored test frame without preamble or check sequence.
  function automatic logic [7:0] romByte(input logic [6:0] i);
    if (i == 7'd0 || i == 7'd6 || i == 7'd11) begin
      return 8'h02;
    end
    if (i == 7'd5) begin
      return 8'h01;
    end
    if (i == 7'd13) begin
      return 8'h2e;
    end
    return (i < 7'd14) ? 8'h00 : {1'b0, i};
  endfunction

  function automatic logic [9:0] swapIdx(input logic [9:0] k,
                                         input logic sw);
    if (!sw || k >= `MLT_HDR_LEN) begin
      return k;
    end
    return (k < `MLT_ADDR_LEN) ? k + `MLT_ADDR_LEN : k - `MLT_ADDR_LEN;
  endfunction

  logic [7:0] testControl;
  logic [7:0] rxStatus;
  logic [7:0] txStatus;
  logic overflow;
  wire swapEn = testControl[`MLT_SWAP_BIT];
  wire drvEnable = testControl[`MLT_DRV_EN_BIT];

  // ==========================================================
  // Loopback FIFO, write side
  mlt_ram_if ramBus();
  mlt_fifo_ram ram (
    .clk(clk),
    .bus(ramBus.store)
  );
  logic [`MLT_FIFO_AW:0] wrPtr;
  logic [`MLT_FIFO_AW:0] commitPtr;
  logic [`MLT_FIFO_AW:0] frameBase;
  logic [`MLT_FIFO_AW:0] txIndex;
  logic dropping;
  mlt_pkg::mlt_lb_state_t lbState;
  wire fifoFull = (wrPtr - frameBase) == 10'(`MLT_FIFO_DEPTH);
  // A frame that overflows is dropped whole, so a torn frame never loops.
  wire rxBad = dropping || fifoFull;
  wire [`MLT_FIFO_AW:0] next_wrPtr = !rxValid ? wrPtr :
    rxBad ? (rxEof ? commitPtr : wrPtr) : wrPtr + 10'd1;
  wire frameReady = commitPtr != frameBase;
  wire [`MLT_FIFO_AW:0] srcIdx = swapIdx(txIndex, swapEn);
  assign ramBus.ce = ce;
  assign ramBus.wrEn = rxValid && !rxBad;
  assign ramBus.wrAddr = wrPtr[`MLT_FIFO_AW-1:0];
  assign ramBus.wrData = {rxEof, rxData};
  assign ramBus.rdAddr = `MLT_FIFO_AW'(frameBase + srcIdx);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      commitPtr <= '0;
      dropping <= 1'b0;
    end else if (ce) begin
      wrPtr <= next_wrPtr;
      if (rxValid && rxEof && !rxBad) begin
        commitPtr <= wrPtr + 10'd1;
      end
      if (rxValid) begin
        dropping <= rxBad && !rxEof;
      end
    end
  end

  // ==========================================================
  // Loopback FIFO, read side toward the transmit client
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lbState <= mlt_pkg::LB_IDLE;
      frameBase <= '0;
      txIndex <= '0;
      txData <= 8'h00;
      txValid <= 1'b0;
      txEof <= 1'b0;
    end else if (ce) begin
      unique case (lbState)
        mlt_pkg::LB_IDLE: begin
          txIndex <= '0;
          if (frameReady) begin
            lbState <= mlt_pkg::LB_FETCH;
          end
        end
        mlt_pkg::LB_FETCH: lbState <= mlt_pkg::LB_WAIT;
        mlt_pkg::LB_WAIT: begin
          {txEof, txData} <= ramBus.rdData;
          txValid <= 1'b1;
          lbState <= mlt_pkg::LB_SEND;
        end
        mlt_pkg::LB_SEND: begin
          if (txReady) begin
            txValid <= 1'b0;
            txIndex <= txIndex + 10'd1;
            if (txEof) begin
              frameBase <= frameBase + txIndex + 10'd1;
              lbState <= mlt_pkg::LB_IDLE;
            end else begin
              lbState <= mlt_pkg::LB_FETCH;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Packet driver toward the secondary link
  mlt_pkg::mlt_drv_state_t drvState;
  logic [6:0] drvIndex;
  logic [31:0] drvCrc;
  logic [7:0] gapCount;
  wire [6:0] drvRomIdx = drvIndex - `MLT_PRE_LEN;
  wire [1:0] fcsSel = 2'(drvIndex - `MLT_FCS_START);
  wire [31:0] drvFcs = ~drvCrc;
  wire drvInData = drvIndex >= `MLT_PRE_LEN && drvIndex < `MLT_FCS_START;
  wire [7:0] drvByte = (drvIndex < `MLT_SFD_IDX) ? `MLT_PREAMBLE :
    (drvIndex == `MLT_SFD_IDX) ? `MLT_SFD :
    drvInData ? romByte(drvRomIdx) : drvFcs[{fcsSel, 3'b000} +: 8];
  wire drvActive = drvState == mlt_pkg::DRV_SEND;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drvState <= mlt_pkg::DRV_IDLE;
      drvIndex <= 7'd0;
      drvCrc <= `MLT_CRC_INIT;
      gapCount <= 8'h00;
    end else if (ce) begin
      unique case (drvState)
        mlt_pkg::DRV_IDLE: begin
          drvIndex <= 7'd0;
          drvCrc <= `MLT_CRC_INIT;
          if (drvEnable) begin
            drvState <= mlt_pkg::DRV_SEND;
          end
        end
        mlt_pkg::DRV_SEND: begin
          drvIndex <= drvIndex + 7'd1;
          if (drvInData) begin
            drvCrc <= crcByte(drvCrc, drvByte);
          end
          if (drvIndex == `MLT_FRAME_LAST) begin
            gapCount <= 8'(`MLT_GAP_CYC);
            drvState <= mlt_pkg::DRV_GAP;
          end
        end
        mlt_pkg::DRV_GAP: begin
          gapCount <= gapCount - 8'h01;
          if (gapCount == 8'h01) begin
            drvState <= mlt_pkg::DRV_IDLE;
          end
        end
        default: drvState <= mlt_pkg::DRV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkTxData <= 8'h00;
      linkTxEn <= 1'b0;
    end else if (ce) begin
      linkTxData <= extSelect ? extTxData : drvByte;
      linkTxEn <= extSelect ? extTxEn : drvActive;
    end
  end

  // ==========================================================
  // Monitor on the returning link
  mlt_pkg::mlt_mon_state_t monState;
  logic [6:0] monIndex;
  logic [31:0] monCrc;
  wire [9:0] monSrc = swapIdx({3'b000, monIndex}, swapEn);
  wire [7:0] monExpect = romByte(monSrc[6:0]);
  wire monInData = monState == mlt_pkg::MON_DATA;
  wire badByte = linkRxDv && monIndex < `MLT_DATA_LEN &&
    linkRxData != monExpect;
  wire badEnd = !linkRxDv &&
    (monIndex != `MLT_MON_LEN || monCrc != `MLT_CRC_RESIDUE);
  wire mismatch = ce && monInData && (badByte || badEnd);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monState <= mlt_pkg::MON_HUNT;
      monIndex <= 7'd0;
      monCrc <= `MLT_CRC_INIT;
      monFail <= 1'b0;
    end else if (ce) begin
      monFail <= monFail || mismatch;
      unique case (monState)
        mlt_pkg::MON_HUNT: begin
          monIndex <= 7'd0;
          monCrc <= `MLT_CRC_INIT;
          if (linkRxDv && linkRxData == `MLT_SFD) begin
            monState <= mlt_pkg::MON_DATA;
          end
        end
        mlt_pkg::MON_DATA: begin
          if (linkRxDv) begin
            monCrc <= crcByte(monCrc, linkRxData);
            if (monIndex != 7'h7f) begin
              monIndex <= monIndex + 7'd1;
            end
          end else begin
            monState <= mlt_pkg::MON_HUNT;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register file on the user slave port
  wire [`MLT_CNT_NUM-1:0] statEv = {txStatEv, rxStatEv};
  logic [15:0] cnt [`MLT_CNT_NUM];
  wire [7:0] cntOff = usAddr - `MLT_CNT_BASE;
  wire cntHit = usAddr >= `MLT_CNT_BASE && usAddr <= `MLT_CNT_END + 8'h1;
  wire [15:0] cntWord = cnt[cntOff[5:1]];
  wire [7:0] cntByte = cntOff[0] ? cntWord[15:8] : cntWord[7:0];
  wire rdRxSts = usRead && usAddr == `MLT_RXSTS_ADDR;
  wire rdTxSts = usRead && usAddr == `MLT_TXSTS_ADDR;
  wire [7:0] regByte = cntHit ? cntByte :
    (usAddr == `MLT_VERSION_ADDR) ? `MLT_VERSION :
    (usAddr == `MLT_TSTCTL_ADDR) ? testControl :
    (usAddr == `MLT_MACCTL_ADDR) ? macControl :
    (usAddr == `MLT_RXSTS_ADDR) ? rxStatus :
    (usAddr == `MLT_TXSTS_ADDR) ? txStatus :
    (usAddr == `MLT_HSTS_ADDR) ? {6'h00, overflow, monFail} : 8'h00;

  for (genvar i = 0; i < `MLT_CNT_NUM; i++) begin : g_cnt
    // Clear wins over nothing; an event in the clearing cycle still counts.
    wire clrLow = usRead && usAddr == `MLT_CNT_BASE + 8'(2 * i);
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt[i] <= 16'h0000;
      end else if (ce) begin
        cnt[i] <= (clrLow ? 16'h0000 : cnt[i]) + {15'h0000, statEv[i]};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      testControl <= `MLT_TSTCTL_RESET;
      macControl <= `MLT_MACCTL_RESET;
      rxStatus <= 8'h00;
      txStatus <= 8'h00;
      overflow <= 1'b0;
      usRdata <= 8'h00;
    end else if (ce) begin
      if (usWrite && usAddr == `MLT_TSTCTL_ADDR) begin
        testControl <= usWdata;
      end
      if (usWrite && usAddr == `MLT_MACCTL_ADDR) begin
        macControl <= usWdata;
      end
      rxStatus <= (rdRxSts ? 8'h00 : rxStatus) | macRxStatus;
      txStatus <= (rdTxSts ? 8'h00 : txStatus) | macTxStatus;
      overflow <= overflow || (rxValid && fifoFull);
      if (usRead) begin
        usRdata <= regByte;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [15:0] cnt0 = cnt[0];
  wire lowRead0 = usRead && usAddr == `MLT_CNT_BASE;

  sequence sTxStall;
    txValid && !txReady;
  endsequence
  sequence sDrvWrap;
    ce && drvActive && drvIndex == `MLT_FRAME_LAST;
  endsequence

  a_tx_hold_stall: assert property (sTxStall |=> txValid && $stable(txData))
    else $error("transmit byte changed while stalled");
  a_swap_dest_src: assert property (ce && lbState == mlt_pkg::LB_FETCH &&
    swapEn && txIndex < `MLT_ADDR_LEN |->
    ramBus.rdAddr == `MLT_FIFO_AW'(frameBase + txIndex + 10'd6))
    else $error("address swap read wrong byte");
  a_drv_gap_follows: assert property (sDrvWrap |=> drvState ==
    mlt_pkg::DRV_GAP && gapCount == 8'(`MLT_GAP_CYC))
    else $error("driver did not enter gap after frame");
  a_link_ext_select: assert property (ce && extSelect |=>
    linkTxEn == $past(extTxEn) && linkTxData == $past(extTxData))
    else $error("external port not routed to link");
  a_mismatch_sets_fail: assert property (mismatch |=> monFail)
    else $error("mismatch did not raise fail");
  a_counter_step: assert property (ce && statEv[0] && !lowRead0 |=>
    cnt0 == $past(cnt0) + 16'h0001)
    else $error("counter did not count event");
  a_macctl_write: assert property (ce && usWrite &&
    usAddr == `MLT_MACCTL_ADDR |=> macControl == $past(usWdata))
    else $error("control write not applied");
  a_high_byte_read: assert property (ce && usRead &&
    usAddr == `MLT_CNT_BASE + 8'h1 |=> usRdata[7:0] == $past(cnt0[15:8]))
    else $error("high byte read wrong");
  a_low_read_clear: assert property (ce && lowRead0 && !statEv[0] |=>
    cnt0 == 16'h0000)
    else $error("low byte read did not clear counter");
  a_fail_sticky: assert property (monFail |=> monFail)
    else $error("fail flag dropped before reset");
endmodule

// file: shared/mlt_pkg.sv
package mlt_pkg;
  typedef enum logic [1:0] {
    LB_IDLE = 2'b00,
    LB_FETCH = 2'b01,
    LB_WAIT = 2'b10,
    LB_SEND = 2'b11
  } mlt_lb_state_t;
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_SEND = 2'b01,
    DRV_GAP = 2'b10
  } mlt_drv_state_t;
  typedef enum logic {
    MON_HUNT = 1'b0,
    MON_DATA = 1'b1
  } mlt_mon_state_t;
endpackage

// file: shared/mlt_ram_if.sv
`timescale 1ns/10ps
`include "mlt_regs.svh"
interface mlt_ram_if;
  logic ce;
  logic wrEn;
  logic [`MLT_FIFO_AW-1:0] wrAddr;
  logic [`MLT_FIFO_AW-1:0] rdAddr;
  logic [`MLT_RAM_DW-1:0] wrData;
  logic [`MLT_RAM_DW-1:0] rdData;
  modport owner(output ce, wrEn, wrAddr, rdAddr, wrData, input rdData);
  modport store(input ce, wrEn, wrAddr, rdAddr, wrData, output rdData);
endinterface

// file: shared/mlt_regs.svh
`ifndef MLT_REGS_SVH
`define MLT_REGS_SVH

// ==========================================================
// Register byte offsets on the user slave port
`define MLT_VERSION_ADDR 8'h40
`define MLT_TSTCTL_ADDR 8'h41
`define MLT_MACCTL_ADDR 8'h43
`define MLT_RXSTS_ADDR 8'h4a
`define MLT_TXSTS_ADDR 8'h4b
`define MLT_CNT_BASE 8'h4c
`define MLT_CNT_END 8'h70
`define MLT_HSTS_ADDR 8'h72
`define MLT_CNT_NUM 19
`define MLT_RX_EV_NUM 12
`define MLT_TX_EV_NUM 7

// ==========================================================
// Fields and reset values
`define MLT_SWAP_BIT 0
`define MLT_DRV_EN_BIT 1
`define MLT_TSTCTL_RESET 8'h00
`define MLT_MACCTL_RESET 8'h00
// Arbitrary identification value.
`define MLT_VERSION 8'h01

// ==========================================================
// Frame layout and timing
`define MLT_FIFO_AW 9
`define MLT_FIFO_DEPTH 512
`define MLT_RAM_DW 9
`define MLT_PREAMBLE 8'h55
`define MLT_SFD 8'hd5
`define MLT_SFD_IDX 7'd7
`define MLT_PRE_LEN 7'd8
`define MLT_FCS_START 7'd68
`define MLT_FRAME_LAST 7'd71
`define MLT_DATA_LEN 7'd60
`define MLT_MON_LEN 7'd64
`define MLT_ADDR_LEN 10'd6
`define MLT_HDR_LEN 10'd12
`define MLT_CRC_POLY 32'hedb88320
`define MLT_CRC_INIT 32'hffffffff
`define MLT_CRC_RESIDUE 32'hdebb20e3
`define MLT_CLK_MHZ 25
`define MLT_GAP_NS 960
`define MLT_GAP_CYC ((`MLT_GAP_NS * `MLT_CLK_MHZ + 999) / 1000)

`endif

// file: sim/mlt_mac_model.sv
`timescale 1ns/10ps
module mlt_mac_model (
  input wire logic clk,
  input wire logic slow,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxEof
);
  logic [3:0] stallCnt = 4'h0;
  initial begin
    txReady = 1'b0;
    rxData = 8'h00;
    rxValid = 1'b0;
    rxEof = 1'b0;
  end
  // ==========================================================
  // Transmit client acceptance
  // A slow partner grants one cycle in four, so every offer must be held.
  always @(negedge clk) begin
    stallCnt <= stallCnt + 4'h1;
    txReady <= !slow || (stallCnt[1:0] == 2'b11);
  end
  // ==========================================================
  // Receive client, one byte per cycle with no gaps inside a frame
  task automatic sendByte(input logic [7:0] d, input logic last);
    @(negedge clk);
    rxData = d;
    rxValid = 1'b1;
    rxEof = last;
  endtask
  // Released data is inverted so a stale byte never looks valid.
  task automatic endFrame();
    @(negedge clk);
    rxValid = 1'b0;
    rxEof = 1'b0;
    rxData = ~rxData;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
`include "mlt_regs.svh"
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic txReady, txValid, txEof, rxValid, rxEof, linkTxEn, monFail;
  logic [7:0] txData, rxData, macControl, usRdata, linkTxData;
  logic [`MLT_RX_EV_NUM-1:0] rxStatEv = '0;
  logic [`MLT_TX_EV_NUM-1:0] txStatEv = '0;
  logic [7:0] macRxStatus = 8'h00;
  logic [7:0] macTxStatus = 8'h00;
  logic [7:0] usAddr = 8'h00;
  logic [7:0] usWdata = 8'h00;
  logic usWrite = 1'b0;
  logic usRead = 1'b0;
  logic extSelect = 1'b0;
  logic [7:0] extTxData = 8'h00;
  logic extTxEn = 1'b0;
  logic [7:0] linkRxData = 8'h00;
  logic linkRxDv = 1'b0;
  logic loopOn = 1'b0;
  logic corrupt = 1'b0;
  logic rdTaken = 1'b0;
  logic [31:0] seed = 32'h00012930;
  logic [8:0] txQ[$];
  logic [7:0] rdQ[$];
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int byteIdx = 0;

  always #20 clk = ~clk;

  mlt_loopback_harness mlt_loopback_harness_inst (
    .clk, .reset_n, .ce, .rxData, .rxValid, .rxEof, .txData, .txValid,
    .txEof, .txReady, .rxStatEv, .txStatEv, .macRxStatus, .macTxStatus,
    .macControl, .usAddr, .usWrite, .usRead, .usWdata, .usRdata,
    .extSelect, .extTxData, .extTxEn, .linkTxData, .linkTxEn, .linkRxData,
    .linkRxDv, .monFail
  );
  mlt_mac_model mlt_mac_model_inst (
    .clk, .slow, .txReady, .rxData, .rxValid, .rxEof
  );

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask
  // A read notes its expected answer; the watcher below compares it.
  task automatic regAccess(input logic [7:0] a, input logic wr,
                           input logic [7:0] d);
    @(negedge clk);
    usAddr = a;
    usWrite = wr;
    usRead = !wr;
    usWdata = d;
    if (!wr) rdQ.push_back(d);
    @(negedge clk);
    usWrite = 1'b0;
    usRead = 1'b0;
  endtask
  task automatic sendFrame(input int len, input logic swap);
    logic [7:0] b[$];
    int k;
    for (k = 0; k < len; k++) b.push_back(rnd());
    for (k = 0; k < len; k++) begin
      txQ.push_back({k == len - 1, b[(swap && k < 12) ? (k + 6) % 12 : k]});
      mlt_mac_model_inst.sendByte(b[k], k == len - 1);
    end
  endtask
  task automatic waitDrain();
    int n;
    n = 0;
    while (txQ.size() != 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("tx drained", 16'(txQ.size()), 16'h0000);
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    if (i < `MLT_RX_EV_NUM) rxStatEv[i] = 1'b1;
    else txStatEv[i - `MLT_RX_EV_NUM] = 1'b1;
    @(negedge clk);
    rxStatEv = '0;
    txStatEv = '0;
  endtask

  // ==========================================================
  // Watchers and link loop
  always @(posedge clk) begin
    if (ce && txValid && txReady) begin
      if (txQ.size() == 0) check("tx extra", {7'h00, txEof, txData}, 16'hffff);
      else check("tx byte", {7'h00, txEof, txData}, {7'h00, txQ.pop_front()});
    end
  end
  always @(posedge clk) rdTaken <= ce && usRead;
  always @(negedge clk) begin
    if (rdTaken) check("read", {8'h00, usRdata}, {8'h00, rdQ.pop_front()});
    linkRxDv = loopOn && linkTxEn;
    if (linkRxDv) begin
      linkRxData = linkTxData ^ ((corrupt && byteIdx == 20) ? 8'h10 : 8'h00);
      byteIdx++;
    end else begin
      linkRxData = ~linkRxData;
      byteIdx = 0;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("MISMATCH timeout expected finish seen hang");
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] a, v, n;
    int i, k;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    regAccess(`MLT_VERSION_ADDR, 1'b0, `MLT_VERSION);
    regAccess(`MLT_VERSION_ADDR, 1'b1, 8'hff);
    regAccess(`MLT_VERSION_ADDR, 1'b0, `MLT_VERSION);
    regAccess(8'h80, 1'b0, 8'h00);
    v = rnd();
    regAccess(`MLT_MACCTL_ADDR, 1'b1, v);
    regAccess(`MLT_MACCTL_ADDR, 1'b0, v);
    check("mac control", {8'h00, macControl}, {8'h00, v});
    for (i = 0; i < 2; i++) begin
      v = rnd() | 8'h01;
      @(negedge clk);
      if (i == 0) macRxStatus = v;
      else macTxStatus = v;
      @(negedge clk);
      macRxStatus = 8'h00;
      macTxStatus = 8'h00;
      regAccess(`MLT_RXSTS_ADDR + 8'(i), 1'b0, v);
      regAccess(`MLT_RXSTS_ADDR + 8'(i), 1'b0, 8'h00);
    end
    done("registers");
    for (i = 0; i < `MLT_CNT_NUM; i++) begin
      a = `MLT_CNT_BASE + 8'(2 * i);
      n = 8'(rnd() % 8'h05) + 8'h01;
      repeat (n) pulse(i);
      // A frozen block must not count an event.
      ce = 1'b0;
      pulse(i);
      ce = 1'b1;
      regAccess(a + 8'h01, 1'b0, 8'h00);
      regAccess(a, 1'b0, n);
      regAccess(a, 1'b0, 8'h00);
      regAccess(a + 8'h01, 1'b0, 8'h00);
    end
    done("counters");
    sendFrame(14, 1'b0);
    mlt_mac_model_inst.endFrame();
    waitDrain();
    // A frame larger than the FIFO is dropped whole and flags overflow.
    for (k = 0; k < `MLT_FIFO_DEPTH + 8; k++) begin
      mlt_mac_model_inst.sendByte(rnd(), k == `MLT_FIFO_DEPTH + 7);
    end
    mlt_mac_model_inst.endFrame();
    regAccess(`MLT_HSTS_ADDR, 1'b0, 8'h02);
    slow = 1'b1;
    sendFrame(20, 1'b0);
    sendFrame(13, 1'b0);
    mlt_mac_model_inst.endFrame();
    waitDrain();
    regAccess(`MLT_TSTCTL_ADDR, 1'b1, 8'h01);
    regAccess(`MLT_TSTCTL_ADDR, 1'b0, 8'h01);
    sendFrame(16, 1'b1);
    mlt_mac_model_inst.endFrame();
    waitDrain();
    slow = 1'b0;
    regAccess(`MLT_TSTCTL_ADDR, 1'b1, 8'h00);
    done("loopback");
    extSelect = 1'b1;
    for (k = 0; k < 12; k++) begin
      @(negedge clk);
      if (k > 0) check("ext data", {8'h00, linkTxData}, {8'h00, extTxData});
      if (k > 0) check("ext enable", {15'h0000, linkTxEn}, {15'h0000, extTxEn});
      extTxData = rnd();
      extTxEn = seed[9];
    end
    @(negedge clk);
    extSelect = 1'b0;
    extTxEn = 1'b0;
    done("external port");
    loopOn = 1'b1;
    regAccess(`MLT_TSTCTL_ADDR, 1'b1, 8'h02);
    k = 0;
    while (linkTxEn !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    for (k = 0; k < 72; k++) begin
      check("link enable", {15'h0000, linkTxEn}, 16'h0001);
      if (k < 8) check("preamble", {8'h00, linkTxData}, {8'h00, (k == 7) ? `MLT_SFD : `MLT_PREAMBLE});
      @(negedge clk);
    end
    for (k = 0; k < 25; k++) begin
      check("link gap", {15'h0000, linkTxEn}, 16'h0000);
      @(negedge clk);
    end
    check("link repeat", {15'h0000, linkTxEn}, 16'h0001);
    check("monitor good", {15'h0000, monFail}, 16'h0000);
    corrupt = 1'b1;
    repeat (90) @(negedge clk);
    corrupt = 1'b0;
    check("monitor bad", {15'h0000, monFail}, 16'h0001);
    regAccess(`MLT_HSTS_ADDR, 1'b0, 8'h03);
    repeat (200) @(negedge clk);
    check("fail sticky", {15'h0000, monFail}, 16'h0001);
    done("driver and monitor");
    loopOn = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check("fail reset", {15'h0000, monFail}, 16'h0000);
    reset_n = 1'b1;
    regAccess(`MLT_MACCTL_ADDR, 1'b0, `MLT_MACCTL_RESET);
    regAccess(`MLT_TSTCTL_ADDR, 1'b0, `MLT_TSTCTL_RESET);
    done("second reset");
    summarize();
  end
endmodule
